// ===== stepper_phase_sequencer.sv
// step sequencer for two bridge drivers of a bipolar stepper motor
//
// Notes on behaviour
// - Wave drive energises one winding at a time in order A, B, A*, B*.
// - Reverse rotation walks the wave sequence in reversed order.
// - Two-phase-on keeps both windings on through AB, A*B, A*B*, AB*.
// - Each two-phase-on step flips the polarity of exactly one winding.
// - Plain half step cycles A, AB, B, A*B, A*, A*B*, B*, AB*.
// - Compensated half step adds 45 degrees per step, 8 per cycle.
// - Level codes are rounded magnitudes of cosine (A) and sine (B).
// - Polarity A is 1 at 0-67.5 and 270-337.5, B is 1 at 0-157.5 degrees.
// - Quarter step has sixteen 22.5 degree entries, codes 15/14/11/6/0.
// - Both short (brake) outputs are held low in every stepping mode.
// - Full step modes drive all-ones level codes on each energised winding.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "stepper_defs.svh"

module stepper_phase_sequencer
  import stepper_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              CLK_I,
  input  wire logic              SRST_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  input  wire logic              STEP_I,
  output logic                   POL_ONE_O,
  output logic                   POL_TWO_O,
  output logic      [3:0]        LEVEL_ONE_O,
  output logic      [3:0]        LEVEL_TWO_O,
  output logic                   WINDING_ONE_SHORT_O,
  output logic                   WINDING_TWO_SHORT_O
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [31:0]             ctrl_q;
  logic [`IDX_WIDTH-1:0]   idx_q;
  logic [`IDX_WIDTH-1:0]   idx_d;
  logic [15:0]             step_cnt_q;
  logic                    step_sync1_q;
  logic                    step_sync2_q;
  logic                    step_prev_q;

  wire logic        acc      = PSEL_I & PENABLE_I;
  wire logic        wr       = acc & PWRITE_I;
  wire logic        hit_ctrl = (PADDR_I == `OFF_CTRL);
  wire logic        hit_step = (PADDR_I == `OFF_STEP);
  wire logic        hit_stat = (PADDR_I == `OFF_STATUS);
  wire logic        hit_pos  = (PADDR_I == `OFF_POS);
  wire logic        mapped   = hit_ctrl | hit_step | hit_stat | hit_pos;
  wire drive_mode_t mode     = drive_mode_t'(ctrl_q[`CTRL_MODE_LSB +: 3]);
  wire logic        dir_rev  = ctrl_q[`CTRL_DIR_BIT];
  wire logic        enable   = ctrl_q[`CTRL_EN_BIT];

  // zero wait state slave, error on unmapped address
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = acc & ~mapped;

  // control register write
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr && hit_ctrl) begin
      ctrl_q <= {26'h0, PWDATA_I[5:0]};
    end
  end

  // read data mux, registered
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= hit_ctrl ? ctrl_q :
                  hit_stat ? {18'h0, LEVEL_TWO_O, LEVEL_ONE_O,
                              POL_TWO_O, POL_ONE_O, idx_q} :
                  hit_pos  ? {16'h0, step_cnt_q} : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // step request: pin edge or bus write
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      step_sync1_q <= 1'b0;
      step_sync2_q <= 1'b0;
      step_prev_q  <= 1'b0;
    end else begin
      step_sync1_q <= STEP_I;
      step_sync2_q <= step_sync1_q;
      step_prev_q  <= step_sync2_q;
    end
  end

  wire logic step_req = enable &
                        ((step_sync2_q & ~step_prev_q) | (wr & hit_step));

  // ---------------------------------------------------------------
  // index walk
  // ---------------------------------------------------------------
  // table length per mode: 16 for quarter, 8 for half, 4 for full
  wire logic [`IDX_WIDTH-1:0] idx_mask =
    (mode == MODE_QUARTER) ? 4'hF :
    (mode == MODE_HALF || mode == MODE_HALF_SINE) ? 4'h7 : 4'h3;
  // up for forward, down for reverse, wrap by mask
  wire logic [`IDX_WIDTH-1:0] idx_step =
    dir_rev ? idx_q - 4'h1 : idx_q + 4'h1;

  assign idx_d = step_req ? (idx_step & idx_mask) : (idx_q & idx_mask);

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      idx_q      <= 4'h0;
      step_cnt_q <= 16'h0000;
    end else begin
      idx_q <= idx_d;
      if (step_req) begin
        step_cnt_q <= dir_rev ? step_cnt_q - 16'h0001 : step_cnt_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // sine tables, sixteen entries at 22.5 degrees
  // ---------------------------------------------------------------
  // magnitude of cosine at index i; sine is cosine shifted by four
  function automatic logic [3:0] cos_mag(input logic [3:0] i);
    case (i)
      4'h0, 4'h8:               cos_mag = `LVL_FULL;
      4'h1, 4'h7, 4'h9, 4'hF:   cos_mag = 4'hE;
      4'h2, 4'h6, 4'hA, 4'hE:   cos_mag = 4'hB;
      4'h3, 4'h5, 4'hB, 4'hD:   cos_mag = 4'h6;
      default:                  cos_mag = `LVL_OFF;
    endcase
  endfunction

  // quarter step index: compensated half step uses every second entry
  wire logic [3:0] qidx = (mode == MODE_QUARTER) ? idx_q :
                          {idx_q[2:0], 1'b0};
  wire logic [3:0] sidx = qidx - 4'h4;
  wire logic [3:0] sin_lvl = cos_mag(sidx);
  wire logic [3:0] cos_lvl = cos_mag(qidx);
  // polarity: A positive 0..<90 or >=270, B positive 0..<180
  wire logic pol_a_sin = (qidx < 4'h4) | (qidx >= 4'hC);
  wire logic pol_b_sin = (qidx < 4'h8);

  // ---------------------------------------------------------------
  // full step and plain half step patterns
  // ---------------------------------------------------------------
  // wave: A, B, A*, B*
  wire logic       wave_on_a = ~idx_q[0];
  wire logic       wave_pol  = ~idx_q[1];
  // two on: AB, A*B, A*B*, AB*; gray order flips one winding per step
  wire logic       two_pol_a = ~(idx_q[0] ^ idx_q[1]);
  wire logic       two_pol_b = ~idx_q[1];
  // half: odd entries both on, even entries one on
  wire logic [2:0] h = idx_q[2:0];
  wire logic       half_on_a = (h != 3'h2) && (h != 3'h6);
  wire logic       half_on_b = (h != 3'h0) && (h != 3'h4);
  wire logic       half_pol_a = (h <= 3'h1) || (h == 3'h7);
  wire logic       half_pol_b = (h <= 3'h3);

  // ---------------------------------------------------------------
  // output selection
  // ---------------------------------------------------------------
  logic       pol_a_d;
  logic       pol_b_d;
  logic [3:0] lvl_a_d;
  logic [3:0] lvl_b_d;

  always_comb begin
    pol_a_d = 1'b1;
    pol_b_d = 1'b1;
    lvl_a_d = `LVL_OFF;
    lvl_b_d = `LVL_OFF;
    case (mode)
      MODE_WAVE: begin
        pol_a_d = wave_pol;
        pol_b_d = wave_pol;
        lvl_a_d = wave_on_a ? `LVL_FULL : `LVL_OFF;
        lvl_b_d = wave_on_a ? `LVL_OFF : `LVL_FULL;
      end
      MODE_TWO_ON: begin
        pol_a_d = two_pol_a;
        pol_b_d = two_pol_b;
        lvl_a_d = `LVL_FULL;
        lvl_b_d = `LVL_FULL;
      end
      MODE_HALF: begin
        pol_a_d = half_pol_a;
        pol_b_d = half_pol_b;
        lvl_a_d = half_on_a ? `LVL_FULL : `LVL_OFF;
        lvl_b_d = half_on_b ? `LVL_FULL : `LVL_OFF;
      end
      MODE_HALF_SINE, MODE_QUARTER: begin
        pol_a_d = pol_a_sin;
        pol_b_d = pol_b_sin;
        lvl_a_d = cos_lvl;
        lvl_b_d = sin_lvl;
      end
      default: begin
        pol_a_d = 1'b1;
        pol_b_d = 1'b1;
      end
    endcase
  end

  // both windings registered together; driver stays off while disabled
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      POL_ONE_O   <= 1'b1;
      POL_TWO_O   <= 1'b1;
      LEVEL_ONE_O <= `LVL_OFF;
      LEVEL_TWO_O <= `LVL_OFF;
    end else begin
      POL_ONE_O   <= pol_a_d;
      POL_TWO_O   <= pol_b_d;
      LEVEL_ONE_O <= enable ? lvl_a_d : `LVL_OFF;
      LEVEL_TWO_O <= enable ? lvl_b_d : `LVL_OFF;
    end
  end

  // short inputs never asserted; supply lockout is the driver's own
  assign WINDING_ONE_SHORT_O = 1'b0;
  assign WINDING_TWO_SHORT_O = 1'b0;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_brake_low;
    @(posedge CLK_I) disable iff (SRST_I)
      !WINDING_ONE_SHORT_O && !WINDING_TWO_SHORT_O;
  endproperty
  a_brake_low: assert property (p_brake_low)
    else $error("short output raised");

  property p_full_level;
    @(posedge CLK_I) disable iff (SRST_I)
      (enable && mode == MODE_TWO_ON) |=> (LEVEL_ONE_O == 4'hF &&
                                          LEVEL_TWO_O == 4'hF);
  endproperty
  a_full_level: assert property (p_full_level)
    else $error("two-on level not full");

  property p_two_on_one_flip;
    @(posedge CLK_I) disable iff (SRST_I)
      (mode == MODE_TWO_ON && $stable(mode) && step_req) |-> ##2
        ((POL_ONE_O != $past(POL_ONE_O)) ^ (POL_TWO_O != $past(POL_TWO_O)));
  endproperty
  a_two_on_one_flip: assert property (p_two_on_one_flip)
    else $error("two-on step did not flip one winding");

  property p_wave_one_on;
    @(posedge CLK_I) disable iff (SRST_I)
      (enable && mode == MODE_WAVE) |=>
        ((LEVEL_ONE_O == 4'h0) != (LEVEL_TWO_O == 4'h0));
  endproperty
  a_wave_one_on: assert property (p_wave_one_on)
    else $error("wave drive not single winding");

  property p_walk;
    @(posedge CLK_I) disable iff (SRST_I)
      (step_req && $stable(mode)) |=>
        (idx_q == ($past(idx_step) & $past(idx_mask)));
  endproperty
  a_walk: assert property (p_walk)
    else $error("index walk wrong");

  property p_hold;
    @(posedge CLK_I) disable iff (SRST_I)
      (!step_req && mode == MODE_QUARTER && $stable(mode)) |=> $stable(idx_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("index moved without request");

  property p_quarter_codes;
    @(posedge CLK_I) disable iff (SRST_I)
      (enable && mode == MODE_QUARTER) |=> (LEVEL_ONE_O inside
        {4'h0, 4'h6, 4'hB, 4'hE, 4'hF});
  endproperty
  a_quarter_codes: assert property (p_quarter_codes)
    else $error("quarter code out of set");

  property p_sine_pol;
    @(posedge CLK_I) disable iff (SRST_I)
      (mode == MODE_HALF_SINE && idx_q == 4'h2) |=> !POL_ONE_O && POL_TWO_O;
  endproperty
  a_sine_pol: assert property (p_sine_pol)
    else $error("polarity at 90 degrees wrong");

endmodule
`default_nettype wire

// ===== stepper_defs.svh
// register offsets, field positions, reset values and table figures
`ifndef STEPPER_DEFS_SVH
`define STEPPER_DEFS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFF_CTRL      12'h000
`define OFF_STEP      12'h004
`define OFF_STATUS    12'h008
`define OFF_POS       12'h00C

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_DIR_BIT  4
`define CTRL_EN_BIT   5
`define CTRL_RESET    32'h0000_0000

// ---------------------------------------------------------------
// table figures
// ---------------------------------------------------------------
`define LVL_FULL      4'hF
`define LVL_OFF       4'h0
`define IDX_WIDTH     4

`endif

// ===== stepper_pkg.sv
// types shared by the sequencer
package stepper_pkg;
  typedef enum logic [2:0] {
    MODE_WAVE,
    MODE_TWO_ON,
    MODE_HALF,
    MODE_HALF_SINE,
    MODE_QUARTER
  } drive_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS
  } bus_state_t;
endpackage

// ===== bridge_drv_model.sv
// behavioural model of one bridge driver fed by the sequencer
`timescale 1ns/1ns
`default_nettype none
module bridge_drv_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] level_i,
  input  wire logic       supply_ok_i,
  output logic            bridge_on_o,
  output logic [3:0]      thr_code_o
);
  // bridge cut under low supply, back on by itself once it recovers
  always_ff @(posedge clk_i) begin
    bridge_on_o <= supply_ok_i;
    thr_code_o  <= level_i;     // unsigned, msb first, D/16
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the stepper phase sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import stepper_pkg::*;
  logic        clk       = 1'b0;
  logic        srst      = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic        step_pin  = 1'b0;
  logic        supply_ok = 1'b1;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, pol_a, pol_b, shrt_a, shrt_b;
  logic        on_a, on_b;
  logic [3:0]  lvl_a, lvl_b, thr_a, thr_b;
  int          n_mismatch = 0;
  int          compares   = 0;

  // -----------------------------------------------------------
  // design, driver models and clock
  // -----------------------------------------------------------
  stepper_phase_sequencer i_dut (.CLK_I(clk), .SRST_I(srst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .STEP_I(step_pin),
    .POL_ONE_O(pol_a), .POL_TWO_O(pol_b), .LEVEL_ONE_O(lvl_a),
    .LEVEL_TWO_O(lvl_b), .WINDING_ONE_SHORT_O(shrt_a),
    .WINDING_TWO_SHORT_O(shrt_b));
  bridge_drv_model i_drv_a (.clk_i(clk), .level_i(lvl_a),
    .supply_ok_i(supply_ok), .bridge_on_o(on_a), .thr_code_o(thr_a));
  bridge_drv_model i_drv_b (.clk_i(clk), .level_i(lvl_b),
    .supply_ok_i(supply_ok), .bridge_on_o(on_b), .thr_code_o(thr_b));
  always #10 clk = ~clk;

  // -----------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------
  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic pin_step();
    step_pin <= 1'b1;
    repeat (3) @(posedge clk);
    step_pin <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // expected {polA, polB, lvlA, lvlB}; every mode is a walk on 22.5 deg
  function automatic logic [9:0] expv(input int m, input int i);
    int q, j, k;
    logic [3:0] mag [5] = '{4'hF, 4'hE, 4'hB, 4'h6, 4'h0};
    logic [9:0] e;
    q = (m == 0) ? 4*i : (m == 1) ? 4*i+2 : (m == 4) ? i : 2*i;
    q = q % 16;
    j = q % 8;
    k = (j <= 4) ? j : 8 - j;
    e = {(q < 4 || q > 11), (q < 8), mag[k], mag[4-k]};
    if (m < 3) begin
      if (e[7:4] != 4'h0) e[7:4] = 4'hF;
      if (e[3:0] != 4'h0) e[3:0] = 4'hF;
    end
    return e;
  endfunction

  // polarity of an unpowered winding is free, so it is not judged
  task automatic check_out(input int m, input int i);
    logic [9:0] e;
    e = expv(m, i);
    if (e[7:4] == 4'h0) e[9] = pol_a;
    if (e[3:0] == 4'h0) e[8] = pol_b;
    chk({22'h0, pol_a, pol_b, lvl_a, lvl_b}, {22'h0, e});
    chk({30'h0, shrt_a, shrt_b}, 32'h0);
  endtask

  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic run_mode(input int m, input logic rev, input logic pin);
    int len, idx, s;
    len = (m < 2) ? 4 : (m == 4) ? 16 : 8;
    do_reset();
    apb(1'b1, 12'h000, {26'h0, 1'b1, rev, 1'b0, m[2:0]});
    idx = 0;
    for (s = 0; s <= len + 1; s++) begin
      if (s > 0) begin
        if (pin) pin_step();
        else apb(1'b1, 12'h004, 32'h1);
        idx = rev ? (idx + len - 1) % len : (idx + 1) % len;
      end
      repeat (2) @(posedge clk);
      check_out(m, idx);
    end
    apb(1'b0, 12'h00C, 32'h0);
    chk({16'h0, rd[15:0]}, {16'h0, rev ? 16'(65536 - len - 1)
                                       : 16'(len + 1)});
  endtask

  task automatic scen_refused();
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic scen_disabled();
    do_reset();
    apb(1'b1, 12'h004, 32'h1);
    pin_step();
    chk({24'h0, lvl_a, lvl_b}, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic scen_supply();
    do_reset();
    apb(1'b1, 12'h000, 32'h0000_0020);
    repeat (3) @(posedge clk);
    chk({24'h0, thr_a, thr_b}, 32'h0000_00F0);
    // status: index 0, both polarities 1, winding A full, B off
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0000_03F0);
    // control readback: enabled, wave, forward
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_0020);
    supply_ok <= 1'b0;
    repeat (2) @(posedge clk);
    chk({30'h0, on_a, on_b}, 32'h0);
    supply_ok <= 1'b1;
    repeat (2) @(posedge clk);
    chk({30'h0, on_a, on_b}, 32'h3);
  endtask

  // -----------------------------------------------------------
  // main sequence and watchdog
  // -----------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    scen_refused();
    scen_disabled();
    run_mode(0, 1'b0, 1'b0);
    run_mode(0, 1'b1, 1'b0);
    run_mode(1, 1'b0, 1'b0);
    run_mode(1, 1'b1, 1'b1);
    run_mode(2, 1'b0, 1'b0);
    run_mode(3, 1'b0, 1'b1);
    run_mode(3, 1'b1, 1'b0);
    run_mode(4, 1'b0, 1'b0);
    run_mode(4, 1'b1, 1'b1);
    scen_supply();
    report_and_stop();
  end

  initial begin
    #1000000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
